// >>> src/dmc_ac_receiver.sv
// gathers the parts of an incoming maintenance message from the snoop address channel
`include "dmc_regs.svh"
module dmc_ac_receiver
	import dmc_pkg::*;
#(
	parameter int ADDR_W = 48
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ac_valid,
	input wire logic [ADDR_W-1:0] ac_addr,
	input wire logic out_ready,
	output logic ac_ready,
	output logic out_valid,
	output dmc_word_t part1,
	output dmc_word_t part2
);
	dmc_rx_t state;
	wire hs = ac_valid & ac_ready;

	// stalling in the output state holds off the interconnect
	assign ac_ready = state != DMC_RX_OUT;
	assign out_valid = state == DMC_RX_OUT;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= DMC_RX_P1;
			part1 <= '0;
			part2 <= '0;
		end else begin
			unique case (state)
				DMC_RX_P1: if (hs) begin
					part1 <= dmc_word_t'(ac_addr);
					part2 <= '0;
					state <= ac_addr[`DMC_B_MULTI] ? DMC_RX_P2 : DMC_RX_OUT;
				end
				DMC_RX_P2: if (hs) begin
					part2 <= dmc_word_t'(ac_addr);
					state <= DMC_RX_OUT;
				end
				DMC_RX_OUT: if (out_ready) state <= DMC_RX_P1;
				default: state <= DMC_RX_P1;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_single;
		state == DMC_RX_P1 && hs && !ac_addr[`DMC_B_MULTI] |=> out_valid && part2 == '0;
	endproperty
	a_single: assert property (p_single)
		else $error("single-part message not presented");
	property p_out_hold;
		out_valid && !out_ready |=> out_valid && $stable(part1) && $stable(part2);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("message dropped while stalled");
endmodule

// >>> src/dmc_ar_sender.sv
// issues a one- or two-part maintenance message on the read address channel
`include "dmc_regs.svh"
module dmc_ar_sender
	import dmc_pkg::*;
#(
	parameter int ADDR_W = 48,
	parameter int ID_W = 4
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire dmc_word_t part1,
	input wire dmc_word_t part2,
	input wire logic [ID_W-1:0] id,
	input wire logic ar_ready,
	output logic busy,
	output logic first,
	output logic ar_valid,
	output logic [ADDR_W-1:0] ar_addr,
	output logic [ID_W-1:0] ar_id
);
	dmc_tx_t state;
	dmc_word_t p2_q;
	wire hs = ar_valid & ar_ready;

	assign ar_valid = state != DMC_TX_IDLE;
	assign busy = ar_valid;
	assign first = state == DMC_TX_P1;

	// part two follows part one directly, with the same id latched at start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= DMC_TX_IDLE;
			ar_addr <= '0;
			ar_id <= '0;
			p2_q <= '0;
		end else begin
			unique case (state)
				DMC_TX_IDLE: if (start) begin
					state <= DMC_TX_P1;
					ar_addr <= part1[ADDR_W-1:0];
					ar_id <= id;
					p2_q <= part2;
				end
				DMC_TX_P1: if (hs) begin
					if (ar_addr[`DMC_B_MULTI]) begin
						state <= DMC_TX_P2;
						ar_addr <= p2_q[ADDR_W-1:0];
					end else begin
						state <= DMC_TX_IDLE;
					end
				end
				DMC_TX_P2: if (hs) state <= DMC_TX_IDLE;
				default: state <= DMC_TX_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_first_taken;
		first && hs && ar_addr[`DMC_B_MULTI];
	endsequence
	property p_back_to_back;
		s_first_taken |=> ar_valid && !first && $stable(ar_id);
	endproperty
	a_back_to_back: assert property (p_back_to_back)
		else $error("second part not issued directly after the first");
	property p_hold;
		ar_valid && !ar_ready |=> ar_valid && $stable(ar_addr) && $stable(ar_id);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request changed before it was taken");
endmodule

// >>> src/dmc_codec.sv
// maintenance message codec: register slave, message encoder and decoder
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`include "dmc_regs.svh"
module dmc_codec
	import dmc_pkg::*;
#(
	parameter bit EXT_PROP = 1'b0,
	parameter bit ASID16 = 1'b0,
	parameter bit SEND_VA = 1'b1,
	parameter bit SEND_PA = 1'b0,
	parameter bit IC_PA_TAG = 1'b0,
	parameter logic [3:0] IC_VA_OP = 4'h1,
	parameter logic [3:0] IC_PA_OP = 4'h2,
	parameter int PA_BITS = 48,
	parameter int VA_BITS = 57,
	parameter int ID_W = 4,
	localparam int VA_BUS = VA_BITS <= 32 ? 32 : VA_BITS <= 41 ? 40 : VA_BITS <= 49 ? 44 : 48,
	localparam int ADDR_W = PA_BITS > VA_BUS ? PA_BITS : VA_BUS
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic ar_valid,
	input wire logic ar_ready,
	output logic [ADDR_W-1:0] ar_addr,
	output logic [ID_W-1:0] ar_id,
	input wire logic ac_valid,
	output logic ac_ready,
	input wire logic [ADDR_W-1:0] ac_addr,
	output logic inv_valid,
	input wire logic inv_ready,
	output dmc_va_t inv_addr,
	output logic inv_pa_fmt,
	output logic [15:0] inv_tag,
	output logic [7:0] inv_vm,
	output logic inv_leaf,
	output logic [1:0] inv_stage,
	output logic [1:0] inv_regime,
	output logic [3:0] inv_op,
	output logic inv_super,
	output logic inv_err
);
	localparam dmc_va_t VA_MASK = dmc_va_t'((58'h1 << VA_BITS) - 58'h1);
	localparam dmc_word_t PA_MASK = dmc_word_t'((49'h1 << PA_BITS) - 49'h1);

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	// ****************************************
	// register slave
	// ****************************************
	logic ack;
	logic [17:0] ctrl;
	logic [31:0] tag_reg;
	logic [31:0] addr_lo;
	logic [24:0] addr_hi;
	logic [ID_W-1:0] id_reg;
	logic refused;
	logic tx_busy;
	logic tx_first;
	logic tx_bad;
	logic [31:0] rd_mux;

	wire req = avs_read | avs_write;
	// every access takes two cycles: read data is registered on the same edge that releases waitrequest
	assign avs_waitrequest = req & ~ack;
	wire wr_en = avs_write & ack;
	wire sel_ctrl = avs_address == `DMC_OFS_CTRL;
	wire sel_tag = avs_address == `DMC_OFS_TAG;
	wire sel_lo = avs_address == `DMC_OFS_ADDR_LO;
	wire sel_hi = avs_address == `DMC_OFS_ADDR_HI;
	wire sel_id = avs_address == `DMC_OFS_ID;
	wire sel_stat = avs_address == `DMC_OFS_STATUS;
	wire [31:0] ctrl_new = be_merge({14'h0, ctrl}, avs_writedata, avs_byteenable);
	wire go = wr_en & sel_ctrl & avs_byteenable[3] & avs_writedata[`DMC_B_GO];
	wire start = go & ~tx_busy & ~tx_bad;
	wire clr_refused = wr_en & sel_stat & avs_byteenable[0] & avs_writedata[`DMC_S_REFUSED];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			avs_readdata <= `DMC_RST_WORD;
		end else begin
			ack <= req & ~ack;
			if (req & ~ack) avs_readdata <= avs_read ? rd_mux : `DMC_RST_WORD;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `DMC_RST_CTRL;
			tag_reg <= `DMC_RST_WORD;
			addr_lo <= `DMC_RST_WORD;
			addr_hi <= '0;
			id_reg <= '0;
		end else if (wr_en) begin
			if (sel_ctrl) ctrl <= ctrl_new[17:0];
			if (sel_tag) tag_reg <= be_merge(tag_reg, avs_writedata, avs_byteenable);
			if (sel_lo) addr_lo <= be_merge(addr_lo, avs_writedata, avs_byteenable);
			if (sel_hi) addr_hi <= 25'(be_merge({7'h0, addr_hi}, avs_writedata, avs_byteenable));
			if (sel_id) id_reg <= ID_W'(be_merge(32'(id_reg), avs_writedata, avs_byteenable));
		end
	end

	// a refusal in the same cycle as its clear stays visible
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) refused <= 1'b0;
		else refused <= (go & (tx_busy | tx_bad)) | (refused & ~clr_refused);
	end

	// ****************************************
	// encoder
	// ****************************************
	// a go write launches with the fields it carries, not the ones it replaces
	wire [17:0] ctrl_eff = (wr_en & sel_ctrl) ? ctrl_new[17:0] : ctrl;
	wire [1:0] tx_stage = ctrl_eff[3:2];
	wire [1:0] tx_regime = ctrl_eff[11:10];
	wire tx_leaf = ctrl_eff[`DMC_B_LEAF];
	wire tx_hint = ctrl_eff[`DMC_B_HINT];
	wire address_space_tag_ok = ctrl_eff[`DMC_B_ASIDV] | tx_hint;
	wire virtual_machine_tag_ok = ctrl_eff[`DMC_B_VMIDV] | tx_hint;
	wire [15:0] address_space_tag_in = tag_reg[15:0];
	// an eight-bit tag always leaves with its upper byte cleared
	wire [7:0] address_space_tag_hi = (ASID16 && EXT_PROP) ? address_space_tag_in[15:8] : 8'h00;
	wire tx_ext = tx_leaf | (tx_stage != `DMC_STAGE_LEGACY) | (tx_regime == `DMC_REGIME_TOP);
	// extended encodings are refused, not silently downgraded, on a legacy-only part
	assign tx_bad = (tx_stage == `DMC_STAGE_RSVD) | (!EXT_PROP & tx_ext);
	// at least one format is always available; stage two forces the physical layout
	wire tx_pa = (tx_stage == `DMC_STAGE_S2) | !SEND_VA | (SEND_PA & ctrl_eff[`DMC_B_PAFMT]);
	wire dmc_va_t tx_va = {addr_hi, addr_lo} & VA_MASK;
	wire dmc_word_t tx_paddr = {addr_hi[15:0], addr_lo} & PA_MASK;
	wire dmc_word_t tx_p1 = {
		tx_pa ? 4'h0 : tx_va[56:53],
		tx_pa ? 4'h0 : tx_va[48:45],
		address_space_tag_ok ? address_space_tag_hi : 8'h00,
		virtual_machine_tag_ok ? tag_reg[23:16] : 8'h00,
		address_space_tag_ok ? address_space_tag_in[7:0] : 8'h00,
		ctrl_eff[15:0]
	};
	wire dmc_word_t tx_p2 = tx_pa ? {tx_paddr[47:4], 4'h0} :
		{tx_va[52:49], tx_va[44:41], tx_va[39:4], tx_va[40], 3'h0};

	dmc_ar_sender #(
		.ADDR_W(ADDR_W),
		.ID_W(ID_W)
	) u_sender (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(start),
		.part1(tx_p1),
		.part2(tx_p2),
		.id(id_reg),
		.ar_ready(ar_ready),
		.busy(tx_busy),
		.first(tx_first),
		.ar_valid(ar_valid),
		.ar_addr(ar_addr),
		.ar_id(ar_id)
	);

	// ****************************************
	// decoder
	// ****************************************
	dmc_word_t rx_p1;
	dmc_word_t rx_p2;
	logic rx_valid;
	wire rx_take = rx_valid & (~inv_valid | inv_ready);

	dmc_ac_receiver #(
		.ADDR_W(ADDR_W)
	) u_receiver (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ac_valid(ac_valid),
		.ac_addr(ac_addr),
		.out_ready(rx_take),
		.ac_ready(ac_ready),
		.out_valid(rx_valid),
		.part1(rx_p1),
		.part2(rx_p2)
	);

	wire [1:0] rx_stage = rx_p1[3:2];
	wire [1:0] rx_regime = rx_p1[11:10];
	wire [3:0] rx_op = rx_p1[15:12];
	wire rx_ext = rx_p1[`DMC_B_LEAF] | (rx_stage != `DMC_STAGE_LEGACY) |
		(rx_regime == `DMC_REGIME_TOP);
	wire rx_err = (rx_stage == `DMC_STAGE_RSVD) | (!EXT_PROP & rx_ext);
	wire rx_ic = (rx_op == IC_PA_OP) | (rx_op == IC_VA_OP);
	wire rx_pa = (rx_stage == `DMC_STAGE_S2) | (rx_op == IC_PA_OP);
	// a cache tagged the other way cannot match the address, so it must drop everything
	wire rx_super = rx_ic & (rx_pa != IC_PA_TAG);
	// an eight-bit receiver over-invalidates rather than comparing the upper byte
	wire [15:0] rx_tag = {ASID16 ? rx_p1[39:32] : 8'h00, rx_p1[23:16]};
	wire dmc_va_t rx_va = {rx_p1[47:44], rx_p2[47:44], rx_p1[43:40], rx_p2[43:40],
		rx_p2[3], rx_p2[39:4], 4'h0} & VA_MASK;
	wire dmc_word_t rx_paddr = {rx_p2[47:4], 4'h0} & PA_MASK;
	wire dmc_va_t rx_addr = rx_pa ? dmc_va_t'(rx_paddr) : rx_va;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inv_valid <= 1'b0;
			inv_addr <= '0;
			inv_pa_fmt <= 1'b0;
			inv_tag <= '0;
			inv_vm <= '0;
			inv_leaf <= 1'b0;
			inv_stage <= `DMC_STAGE_LEGACY;
			inv_regime <= 2'b00;
			inv_op <= 4'h0;
			inv_super <= 1'b0;
			inv_err <= 1'b0;
		end else begin
			inv_valid <= rx_take | (inv_valid & ~inv_ready);
			if (rx_take) begin
				inv_addr <= rx_addr;
				inv_pa_fmt <= rx_pa;
				inv_tag <= rx_tag;
				inv_vm <= rx_p1[31:24];
				inv_leaf <= rx_p1[`DMC_B_LEAF];
				inv_stage <= rx_stage;
				inv_regime <= rx_regime;
				inv_op <= rx_op;
				inv_super <= rx_super;
				inv_err <= rx_err;
			end
		end
	end

	// ****************************************
	// read-back
	// ****************************************
	wire [31:0] stat_word = 32'({ASID16, EXT_PROP, 5'h00, inv_valid, refused, tx_busy});
	wire [31:0] info_word = 32'({inv_err, inv_super, inv_pa_fmt, inv_op, inv_regime,
		inv_stage, inv_leaf});
	assign rd_mux = sel_ctrl ? {14'h0, ctrl} :
		sel_tag ? tag_reg :
		sel_lo ? addr_lo :
		sel_hi ? {7'h0, addr_hi} :
		sel_id ? 32'(id_reg) :
		sel_stat ? stat_word :
		(avs_address == `DMC_OFS_RX_TAG) ? {8'h00, inv_vm, inv_tag} :
		(avs_address == `DMC_OFS_RX_LO) ? inv_addr[31:0] :
		(avs_address == `DMC_OFS_RX_HI) ? {7'h0, inv_addr[56:32]} :
		(avs_address == `DMC_OFS_RX_INFO) ? info_word :
		`DMC_RST_WORD;

	// ****************************************
	// checks
	// ****************************************
	wire dmc_word_t ar48 = dmc_word_t'(ar_addr);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_legacy_tx;
		ar_valid && tx_first && !EXT_PROP |-> ar48[4] == 1'b0 && ar48[3:2] == 2'b00 &&
			ar48[11:10] != `DMC_REGIME_TOP;
	endproperty
	a_legacy_tx: assert property (p_legacy_tx)
		else $error("extended encoding sent by a legacy part");
	property p_tag_hi_zero;
		ar_valid && tx_first && !ASID16 |-> ar48[39:32] == 8'h00;
	endproperty
	a_tag_hi_zero: assert property (p_tag_hi_zero)
		else $error("upper tag byte nonzero from eight-bit sender");
	property p_unflagged_zero;
		start && !address_space_tag_ok && !virtual_machine_tag_ok |=> ar48[39:16] == 24'h00_0000;
	endproperty
	a_unflagged_zero: assert property (p_unflagged_zero)
		else $error("tag fields not cleared");
	property p_refuse;
		go && tx_bad |=> refused && !$rose(tx_busy);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("bad request not refused");
	property p_s2_layout;
		start && tx_stage == `DMC_STAGE_S2 |=> ar48[47:40] == 8'h00;
	endproperty
	a_s2_layout: assert property (p_s2_layout)
		else $error("stage two request not in physical layout");
	property p_rx_tag;
		inv_valid && !ASID16 |-> inv_tag[15:8] == 8'h00;
	endproperty
	a_rx_tag: assert property (p_rx_tag)
		else $error("upper tag byte used by eight-bit receiver");
	property p_rx_mask;
		inv_valid && !inv_pa_fmt |-> (inv_addr & ~VA_MASK) == '0;
	endproperty
	a_rx_mask: assert property (p_rx_mask)
		else $error("unsupported address bits kept");
	property p_super;
		rx_take && rx_ic && (rx_pa != IC_PA_TAG) |=> inv_valid && inv_super;
	endproperty
	a_super: assert property (p_super)
		else $error("format mismatch without superset invalidation");
	property p_reserved;
		rx_take && rx_stage == `DMC_STAGE_RSVD |=> inv_valid && inv_err;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved stage not flagged");
	property p_fields;
		rx_take |=> inv_leaf == $past(rx_p1[4]) && inv_regime == $past(rx_regime);
	endproperty
	a_fields: assert property (p_fields)
		else $error("leaf or regime field lost");
	sequence s_bus_wait;
		req && avs_waitrequest;
	endsequence
	property p_bus_answer;
		s_bus_wait ##1 req |-> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus access not answered in two cycles");
endmodule

// >>> src/dmc_pkg.sv
// types shared by the maintenance message codec
package dmc_pkg;
	typedef enum logic [1:0] {DMC_TX_IDLE, DMC_TX_P1, DMC_TX_P2} dmc_tx_t;
	typedef enum logic [1:0] {DMC_RX_P1, DMC_RX_P2, DMC_RX_OUT} dmc_rx_t;
	typedef logic [47:0] dmc_word_t;
	typedef logic [56:0] dmc_va_t;
endpackage

// >>> src/dmc_regs.svh
// register offsets, field positions and reset values of the maintenance message codec
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_OFS_CTRL 8'h00
`define DMC_OFS_TAG 8'h04
`define DMC_OFS_ADDR_LO 8'h08
`define DMC_OFS_ADDR_HI 8'h0C
`define DMC_OFS_ID 8'h10
`define DMC_OFS_STATUS 8'h14
`define DMC_OFS_RX_TAG 8'h18
`define DMC_OFS_RX_LO 8'h1C
`define DMC_OFS_RX_HI 8'h20
`define DMC_OFS_RX_INFO 8'h24
`define DMC_B_MULTI 0
`define DMC_B_LEAF 4
`define DMC_B_ASIDV 5
`define DMC_B_VMIDV 6
`define DMC_B_PAFMT 16
`define DMC_B_HINT 17
`define DMC_B_GO 31
`define DMC_S_BUSY 0
`define DMC_S_REFUSED 1
`define DMC_S_RXPEND 2
`define DMC_S_EXT 8
`define DMC_S_TAG16 9
`define DMC_STAGE_LEGACY 2'b00
`define DMC_STAGE_S2 2'b10
`define DMC_STAGE_RSVD 2'b11
`define DMC_REGIME_TOP 2'b01
`define DMC_RST_CTRL 18'h0_0000
`define DMC_RST_WORD 32'h0000_0000
`endif

// >>> verification/dmc_codec_tb_top.sv
// self-checking testbench of the maintenance message codec
`include "dmc_regs.svh"
module dmc_codec_tb_top import dmc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, stall, inv_ready;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, ar_id, inv_op;
	logic ar_valid, ar_ready, ac_valid, ac_ready, inv_valid, inv_pa_fmt;
	logic [47:0] ar_addr, ac_addr;
	dmc_va_t inv_addr;
	logic [15:0] inv_tag;
	logic [7:0] inv_vm;
	logic inv_leaf, inv_super, inv_err;
	logic [1:0] inv_stage, inv_regime;
	int errors = 0;
	int num_checks = 0;
	dmc_va_t va = 57'h1AB_CDEF_0123_4560;
	dmc_word_t rp1[4] = '{48'hA5C3_7721_1C75, 48'h0000_0000_2801, 48'h0000_0000_000C,
		48'h0000_0000_3409};
	dmc_word_t rp2[4] = '{48'h6B2F_0123_4568, 48'h0123_4567_89A0, 48'h0000_0000_0000,
		48'hFEDC_BA98_7650};
	dmc_word_t a, b;
	logic pf;

	dmc_codec #(.EXT_PROP(1'b1), .SEND_PA(1'b1)) u_dut (.clk_sys, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .ar_valid, .ar_ready, .ar_addr, .ar_id, .ac_valid, .ac_ready,
		.ac_addr, .inv_valid, .inv_ready, .inv_addr, .inv_pa_fmt, .inv_tag, .inv_vm,
		.inv_leaf, .inv_stage, .inv_regime, .inv_op, .inv_super, .inv_err);
	dmc_ic_model u_ic (.clk_sys, .rst_n, .stall, .ar_valid, .ar_ready, .ar_addr, .ar_id,
		.ac_valid, .ac_ready, .ac_addr);

	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 100) errors++;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask
	task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, ad, 32'h0000_0000, q);
		chk(nm, e, q);
	endtask
	// waits for both parts, then checks layout, shared id and adjacency
	task automatic take(input dmc_word_t e1, input dmc_word_t e2);
		int n;
		n = 0;
		while (u_ic.q_addr.size() < 2 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("part one", e1, u_ic.q_addr[0]);
		chk("part two", e2, u_ic.q_addr[1]);
		chk("part ids", 8'h99, {u_ic.q_id[0], u_ic.q_id[1]});
		chk("part gap", 1, u_ic.q_cyc[1] - u_ic.q_cyc[0]);
		u_ic.q_addr.delete();
		u_ic.q_id.delete();
		u_ic.q_cyc.delete();
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************
	// clock, watchdog, tests
	// ****************
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		complete_run;
	end
	initial begin
		rst_n = 1'b0;
		stall = 1'b0;
		inv_ready = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd("status", `DMC_OFS_STATUS, 32'h0000_0100);
		rd("ctrl", `DMC_OFS_CTRL, 32'h0000_0000);
		rd("unmapped", 8'h3C, 32'h0000_0000);
		$display("test registers done");
		wr(`DMC_OFS_ID, 32'h0000_0009);
		wr(`DMC_OFS_TAG, 32'h005C_AB12);
		wr(`DMC_OFS_ADDR_LO, va[31:0]);
		wr(`DMC_OFS_ADDR_HI, {7'h00, va[56:32]});
		wr(`DMC_OFS_CTRL, 32'h8000_3475);
		take({va[56:53], va[48:45], 24'h00_5C12, 16'h3475},
			{va[52:49], va[44:41], va[39:4], va[40], 3'b000});
		// far side stalls; the request must wait whole
		stall <= 1'b1;
		wr(`DMC_OFS_CTRL, 32'h8000_3009);
		repeat (4) @(posedge clk_sys);
		rd("busy", `DMC_OFS_STATUS, 32'h0000_0101);
		chk("no beat while stalled", 0, u_ic.q_addr.size());
		stall <= 1'b0;
		take({32'h0000_0000, 16'h3009}, {va[47:4], 4'h0});
		wr(`DMC_OFS_CTRL, 32'h8001_2021);
		take({32'h0000_0012, 16'h2021}, {va[47:4], 4'h0});
		// a hint keeps its tag fields although neither valid flag is set
		wr(`DMC_OFS_CTRL, 32'h8002_1001);
		take({va[56:53], va[48:45], 24'h00_5C12, 16'h1001},
			{va[52:49], va[44:41], va[39:4], va[40], 3'b000});
		$display("test sender done");
		wr(`DMC_OFS_CTRL, 32'h8000_000D);
		repeat (4) @(posedge clk_sys);
		chk("reserved stage sent", 0, u_ic.q_addr.size());
		rd("refused", `DMC_OFS_STATUS, 32'h0000_0102);
		wr(`DMC_OFS_STATUS, 32'h0000_0002);
		rd("refused clear", `DMC_OFS_STATUS, 32'h0000_0100);
		$display("test refusal done");
		for (int i = 0; i < 4; i++) begin
			a = rp1[i];
			b = rp2[i];
			pf = (a[3:2] == 2'b10) || (a[15:12] == 4'h2);
			u_ic.send(a);
			if (a[0]) u_ic.send(b);
			for (int n = 0; n < 100 && inv_valid !== 1'b1; n++) @(posedge clk_sys);
			repeat (2) @(posedge clk_sys);
			chk("inv_valid held", 1, inv_valid);
			chk("inv_addr", pf ? {9'h000, b[47:4], 4'h0} :
				{a[47:44], b[47:44], a[43:40], b[43:40], b[3], b[39:4], 4'h0},
				inv_addr);
			chk("inv_pa_fmt", pf, inv_pa_fmt);
			chk("inv_tag", {8'h00, a[23:16]}, inv_tag);
			chk("inv_vm", a[31:24], inv_vm);
			chk("inv_leaf", a[4], inv_leaf);
			chk("inv_stage", a[3:2], inv_stage);
			chk("inv_regime", a[11:10], inv_regime);
			chk("inv_op", a[15:12], inv_op);
			chk("inv_super", a[15:12] == 4'h2, inv_super);
			chk("inv_err", a[3:2] == 2'b11, inv_err);
			rd("rx tag", `DMC_OFS_RX_TAG, {8'h00, a[31:24], 8'h00, a[23:16]});
			rd("rx info", `DMC_OFS_RX_INFO, 32'({a[3:2] == 2'b11, a[15:12] == 4'h2, pf,
				a[15:12], a[11:10], a[3:2], a[4]}));
			inv_ready <= 1'b1;
			@(posedge clk_sys);
			inv_ready <= 1'b0;
			@(posedge clk_sys);
			chk("inv_valid drop", 0, inv_valid);
		end
		$display("test receiver done");
		complete_run;
	end
endmodule

// >>> verification/dmc_ic_model.sv
// interconnect model: takes read address beats and issues snoop address parts
module dmc_ic_model #(
	parameter int ADDR_W = 48,
	parameter int ID_W = 4
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic ar_valid,
	output logic ar_ready,
	input wire logic [ADDR_W-1:0] ar_addr,
	input wire logic [ID_W-1:0] ar_id,
	output logic ac_valid,
	input wire logic ac_ready,
	output logic [ADDR_W-1:0] ac_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] q_addr[$];
	logic [ID_W-1:0] q_id[$];
	int q_cyc[$];
	int cyc = 0;
	initial begin
		ac_valid = 1'b0;
		ac_addr = '1;
	end
	// beats are logged with their cycle so any gap between parts shows up
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ar_ready <= 1'b0;
		end else begin
			cyc <= cyc + 1;
			ar_ready <= ~stall;
			if (ar_valid && ar_ready) begin
				q_addr.push_back(ar_addr);
				q_id.push_back(ar_id);
				q_cyc.push_back(cyc);
			end
		end
	end
	// caller encodes leaf, stage and regime in part one; a released bus shows the inverse
	task automatic send(input logic [ADDR_W-1:0] a);
		int n;
		@(posedge clk_sys);
		ac_valid <= 1'b1;
		ac_addr <= a;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ac_ready !== 1'b1 && n < 200);
		ac_valid <= 1'b0;
		ac_addr <= ~a;
	endtask
endmodule
